// File: logic/cmc_move.sv
// Cartridge move command interpreter with its AHB-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
module cmc_move #(
  parameter logic [15:0] HANDLER_DEFAULT = cmc_pkg::HANDLER_RESET  // Handler address after reset.
) (
  input  wire logic        hclk,           // System clock, 100 MHz.
  input  wire logic        hresetn,        // Asynchronous reset, active low.
  input  wire logic        hsel,           // Slave select.
  input  wire logic [31:0] haddr,          // Byte address.
  input  wire logic [1:0]  htrans,         // Transfer type.
  input  wire logic        hwrite,         // Write transfer.
  input  wire logic [2:0]  hsize,          // Transfer size, word only.
  input  wire logic [31:0] hwdata,         // Write data.
  input  wire logic        hready,         // Bus ready.
  output logic             hreadyout,      // Slave ready.
  output logic             hresp,          // Always OKAY.
  output logic [31:0]      hrdata,         // Read data.
  output logic [15:0]      q_addr,         // Element address looked up.
  input  wire logic        q_valid,        // Address names a real element.
  input  wire logic        q_full,         // Element holds a cartridge.
  input  wire logic [1:0]  q_type,         // Element type.
  input  wire logic        q_ejected,      // Drive tape is ejected.
  input  wire logic        q_installed,    // Magazine or drive is installed.
  input  wire logic        handler_full,   // Handler already holds a cartridge.
  output logic             pick_req,       // Request handler to take from pick_src.
  output logic [15:0]      pick_src,       // Source element of the move.
  input  wire logic        picked,         // Pulse: cartridge now in the handler.
  output logic             place_req,      // Request handler to place at place_dst.
  output logic [15:0]      place_dst,      // Destination element of the move.
  input  wire logic        placed,         // Pulse: cartridge now in destination.
  input  wire logic        move_fail,      // Pulse: no free slot or operator abort.
  output logic             inv_wr,         // Pulse: inventory update.
  output logic [15:0]      inv_addr,       // Element being updated.
  output logic             inv_full,       // New occupancy of that element.
  output logic             port_extended,  // Port commanded extended.
  input  wire logic        cart_inserted   // Pulse: cartridge inserted in port.
);

  //--------------------------------------------------------------------------
  // Bus slave
  //--------------------------------------------------------------------------
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic        rd_wait_reg;
  logic [7:0]  dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_mux;
  logic [15:0] trans_reg;
  logic [15:0] src_reg;
  logic [15:0] dst_reg;
  logic [7:0]  ctrl_reg;
  logic [cmc_pkg::CFG_W-1:0] cfg_reg;
  logic [15:0] handler_reg;
  logic        done_reg;
  logic        check_reg;
  logic        port_ext_reg;
  logic        port_ext_next;

  wire         addr_phase = hsel & htrans[1] & hready;
  wire         wr_now     = wr_pend_reg;
  wire         wr_trans   = wr_now & (dp_addr_reg == cmc_pkg::ADDR_TRANSPORT);
  wire         wr_src     = wr_now & (dp_addr_reg == cmc_pkg::ADDR_SOURCE);
  wire         wr_dst     = wr_now & (dp_addr_reg == cmc_pkg::ADDR_DEST);
  wire         wr_ctrl    = wr_now & (dp_addr_reg == cmc_pkg::ADDR_CONTROL);
  wire         wr_cfg     = wr_now & (dp_addr_reg == cmc_pkg::ADDR_CONFIG);
  wire         wr_hdl     = wr_now & (dp_addr_reg == cmc_pkg::ADDR_HANDLER);
  wire         wr_go      = wr_now & (dp_addr_reg == cmc_pkg::ADDR_GO) & hwdata[0];

  cmc_pkg::cmc_state_t state_reg;
  cmc_pkg::cmc_state_t state_next;
  cmc_pkg::cmc_sense_t sense_q;
  wire         busy  = (state_reg != cmc_pkg::CMC_IDLE);
  wire         start = wr_go & ~busy;

  assign hreadyout = ~(rd_pend_reg & ~rd_wait_reg);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_addr_reg == cmc_pkg::ADDR_TRANSPORT) begin
      rd_mux[15:0] = trans_reg;
    end else if (dp_addr_reg == cmc_pkg::ADDR_SOURCE) begin
      rd_mux[15:0] = src_reg;
    end else if (dp_addr_reg == cmc_pkg::ADDR_DEST) begin
      rd_mux[15:0] = dst_reg;
    end else if (dp_addr_reg == cmc_pkg::ADDR_CONTROL) begin
      rd_mux[7:0] = ctrl_reg;
    end else if (dp_addr_reg == cmc_pkg::ADDR_STATUS) begin
      rd_mux[cmc_pkg::STAT_BUSY]     = busy;
      rd_mux[cmc_pkg::STAT_DONE]     = done_reg;
      rd_mux[cmc_pkg::STAT_CHECK]    = check_reg;
      rd_mux[cmc_pkg::STAT_PORT_EXT] = port_ext_reg;
    end else if (dp_addr_reg == cmc_pkg::ADDR_CONFIG) begin
      rd_mux[cmc_pkg::CFG_W-1:0] = cfg_reg;
    end else if (dp_addr_reg == cmc_pkg::ADDR_HANDLER) begin
      rd_mux[15:0] = handler_reg;
    end else if (dp_addr_reg == cmc_pkg::ADDR_SENSE0) begin
      rd_mux = {1'b0, sense_q.bp, 2'b00, sense_q.bpv, sense_q.cd, sense_q.ascq, sense_q.asc, 4'h0, sense_q.key};
    end else if (dp_addr_reg == cmc_pkg::ADDR_SENSE1) begin
      rd_mux[15:0] = sense_q.fp;
    end
  end

  // Reads take one wait state so that a write just before is seen.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      if (hreadyout) begin
        wr_pend_reg <= addr_phase & hwrite;
        rd_pend_reg <= addr_phase & ~hwrite;
        rd_wait_reg <= 1'b0;
        if (addr_phase) begin
          dp_addr_reg <= {haddr[7:2], 2'b00};
        end
      end else begin
        rd_wait_reg <= 1'b1;
        hrdata_reg  <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trans_reg   <= 16'h0000;
      src_reg     <= 16'h0000;
      dst_reg     <= 16'h0000;
      ctrl_reg    <= 8'h00;
      cfg_reg     <= cmc_pkg::CONFIG_RESET;
      handler_reg <= HANDLER_DEFAULT;
    end else begin
      if (wr_trans & ~busy) trans_reg <= hwdata[15:0];
      if (wr_src & ~busy) src_reg <= hwdata[15:0];
      if (wr_dst & ~busy) dst_reg <= hwdata[15:0];
      if (wr_ctrl & ~busy) ctrl_reg <= hwdata[7:0];
      if (wr_cfg) cfg_reg <= hwdata[cmc_pkg::CFG_W-1:0];
      if (wr_hdl) handler_reg <= hwdata[15:0];
    end
  end

  //--------------------------------------------------------------------------
  // Command checks
  //--------------------------------------------------------------------------
  wire [1:0]  port_code  = ctrl_reg[cmc_pkg::CTRL_PORT_LSB +: 2];
  wire        cfg_import = cfg_reg[cmc_pkg::CFG_IMPORT];
  wire        cfg_export = cfg_reg[cmc_pkg::CFG_EXPORT];
  wire        cfg_front  = cfg_reg[cmc_pkg::CFG_FRONT];
  wire        cfg_prev   = cfg_reg[cmc_pkg::CFG_PREVENT];
  wire        same_elem  = (src_reg == dst_reg);
  wire        is_slot    = (q_type == cmc_pkg::CMC_EL_SLOT);
  wire        is_port    = (q_type == cmc_pkg::CMC_EL_PORT);
  wire        is_drive   = (q_type == cmc_pkg::CMC_EL_DRIVE);
  wire        need_inst  = is_slot | is_drive;

  // Transport zero stands for the handler itself.
  wire        trans_bad  = (trans_reg != cmc_pkg::ADDR_ZERO) & (trans_reg != handler_reg);

  cmc_pkg::cmc_sense_t port_err;
  cmc_pkg::cmc_sense_t src_err;
  cmc_pkg::cmc_sense_t dst_err;

  // Port command errors, tested before any address field is looked at.
  assign port_err = (port_code == cmc_pkg::PORT_ILLEGAL) ? cmc_pkg::SNS_ILLEGAL :
                    cfg_front                            ? cmc_pkg::SNS_CFG_PORT :
                    ((port_code == cmc_pkg::PORT_EXTEND) & cfg_prev) ? cmc_pkg::SNS_PREVENTED :
                    cmc_pkg::SNS_NONE;

  assign src_err = ~q_valid                ? cmc_pkg::SNS_BAD_SRC :
                   (need_inst & ~q_installed) ? (is_slot ? cmc_pkg::SNS_NO_SRC_MAG
                                                         : cmc_pkg::SNS_NO_SRC_DRV) :
                   (is_port & ~cfg_import) ? cmc_pkg::SNS_CFG_SRC :
                   ~q_full                 ? cmc_pkg::SNS_SRC_EMPTY :
                   (is_drive & ~q_ejected) ? cmc_pkg::SNS_NOT_EJECT :
                   cmc_pkg::SNS_NONE;

  assign dst_err = ~q_valid                ? cmc_pkg::SNS_BAD_DST :
                   (need_inst & ~q_installed) ? (is_slot ? cmc_pkg::SNS_NO_DST_MAG
                                                         : cmc_pkg::SNS_NO_DST_DRV) :
                   (is_port & ~cfg_export) ? cmc_pkg::SNS_CFG_DST :
                   q_full                  ? cmc_pkg::SNS_DST_FULL :
                   handler_full            ? cmc_pkg::SNS_HANDLER :
                   cmc_pkg::SNS_NONE;

  wire port_fail = (port_err.key != 4'h0);
  wire src_fail  = (src_err.key != 4'h0);
  wire dst_fail  = (dst_err.key != 4'h0);

  //--------------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------------
  logic                finish_good;
  logic                finish_bad;
  cmc_pkg::cmc_sense_t bad_sense;

  always_comb begin
    state_next  = state_reg;
    finish_good = 1'b0;
    finish_bad  = 1'b0;
    bad_sense   = cmc_pkg::SNS_NONE;
    case (state_reg)
      cmc_pkg::CMC_IDLE: begin
        if (start) begin
          state_next = cmc_pkg::CMC_CHK_T;
        end
      end
      cmc_pkg::CMC_CHK_T: begin
        if (port_code != cmc_pkg::PORT_NORMAL) begin
          state_next  = cmc_pkg::CMC_IDLE;
          finish_bad  = port_fail;
          finish_good = ~port_fail;
          bad_sense   = port_err;
        end else if (trans_bad) begin
          state_next = cmc_pkg::CMC_IDLE;
          finish_bad = 1'b1;
          bad_sense  = cmc_pkg::SNS_BAD_TRANS;
        end else begin
          state_next = cmc_pkg::CMC_CHK_S;
        end
      end
      cmc_pkg::CMC_CHK_S: begin
        if (src_fail) begin
          state_next = cmc_pkg::CMC_IDLE;
          finish_bad = 1'b1;
          bad_sense  = src_err;
        end else if (same_elem & ~is_drive) begin
          state_next  = cmc_pkg::CMC_IDLE;
          finish_good = 1'b1;
        end else if (same_elem) begin
          state_next = cmc_pkg::CMC_PICK;
        end else begin
          state_next = cmc_pkg::CMC_CHK_D;
        end
      end
      cmc_pkg::CMC_CHK_D: begin
        if (dst_fail) begin
          state_next = cmc_pkg::CMC_IDLE;
          finish_bad = 1'b1;
          bad_sense  = dst_err;
        end else begin
          state_next = cmc_pkg::CMC_PICK;
        end
      end
      cmc_pkg::CMC_PICK: begin
        if (move_fail) begin
          state_next = cmc_pkg::CMC_IDLE;
          finish_bad = 1'b1;
          bad_sense  = cmc_pkg::SNS_NOT_READY;
        end else if (picked) begin
          state_next = cmc_pkg::CMC_INV_H1;
        end
      end
      cmc_pkg::CMC_INV_H1: begin
        state_next = cmc_pkg::CMC_PLACE;
      end
      cmc_pkg::CMC_PLACE: begin
        if (move_fail) begin
          state_next = cmc_pkg::CMC_IDLE;
          finish_bad = 1'b1;
          bad_sense  = cmc_pkg::SNS_NOT_READY;
        end else if (placed) begin
          state_next = cmc_pkg::CMC_INV_H0;
        end
      end
      cmc_pkg::CMC_INV_H0: begin
        state_next  = cmc_pkg::CMC_IDLE;
        finish_good = 1'b1;
      end
      default: begin
        state_next = cmc_pkg::CMC_IDLE;
      end
    endcase
  end

  // Lookup address follows the element under test.
  assign q_addr    = (state_reg == cmc_pkg::CMC_CHK_D) ? dst_reg : src_reg;
  assign pick_req  = (state_reg == cmc_pkg::CMC_PICK);
  assign place_req = (state_reg == cmc_pkg::CMC_PLACE);
  assign pick_src  = src_reg;
  assign place_dst = dst_reg;

  // Inventory steps: source empty, handler full, handler empty, destination full.
  wire step_pick  = (state_reg == cmc_pkg::CMC_PICK) & picked & ~move_fail;
  wire step_place = (state_reg == cmc_pkg::CMC_PLACE) & placed & ~move_fail;
  wire step_h1    = (state_reg == cmc_pkg::CMC_INV_H1);
  wire step_h0    = (state_reg == cmc_pkg::CMC_INV_H0);
  logic        inv_wr_reg;
  logic [15:0] inv_addr_reg;
  logic        inv_full_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inv_wr_reg   <= 1'b0;
      inv_addr_reg <= 16'h0000;
      inv_full_reg <= 1'b0;
    end else begin
      inv_wr_reg   <= step_pick | step_h1 | step_place | step_h0;
      inv_addr_reg <= step_pick ? src_reg : ((step_h1 | step_place) ? handler_reg : dst_reg);
      inv_full_reg <= step_h1 | step_h0;
    end
  end

  assign inv_wr   = inv_wr_reg;
  assign inv_addr = inv_addr_reg;
  assign inv_full = inv_full_reg;

  // Port state; extend wins over an insertion in the same cycle.
  wire port_ok  = (state_reg == cmc_pkg::CMC_CHK_T) & ~port_fail;
  wire do_ext   = port_ok & (port_code == cmc_pkg::PORT_EXTEND);
  wire do_ret   = port_ok & (port_code == cmc_pkg::PORT_RETRACT);
  assign port_ext_next = do_ext ? 1'b1 : ((do_ret | cart_inserted) ? 1'b0 : port_ext_reg);
  assign port_extended = port_ext_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= cmc_pkg::CMC_IDLE;
      done_reg     <= 1'b0;
      check_reg    <= 1'b0;
      port_ext_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      port_ext_reg <= port_ext_next;
      done_reg     <= (finish_good | finish_bad) | (done_reg & ~start);
      check_reg    <= finish_bad | (check_reg & ~start);
    end
  end

  cmc_sense_latch u_sense (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .set       (finish_bad),
    .sense_in  (bad_sense),
    .sense_out (sense_q)
  );

endmodule
`default_nettype wire

// File: logic/cmc_pkg.sv
// Constants, register map and sense codes for the cartridge move command block.
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package cmc_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_TRANSPORT = 8'h00;
  localparam logic [7:0] ADDR_SOURCE    = 8'h04;
  localparam logic [7:0] ADDR_DEST      = 8'h08;
  localparam logic [7:0] ADDR_CONTROL   = 8'h0c;
  localparam logic [7:0] ADDR_GO        = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_CONFIG    = 8'h18;
  localparam logic [7:0] ADDR_HANDLER   = 8'h1c;
  localparam logic [7:0] ADDR_SENSE0    = 8'h20;
  localparam logic [7:0] ADDR_SENSE1    = 8'h24;

  // Field positions.
  localparam int CTRL_PORT_LSB  = 6;
  localparam int CTRL_INVERT    = 0;
  localparam int CFG_IMPORT     = 0;
  localparam int CFG_EXPORT     = 1;
  localparam int CFG_FRONT      = 2;
  localparam int CFG_PREVENT    = 3;
  localparam int CFG_W          = 4;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_DONE      = 1;
  localparam int STAT_CHECK     = 2;
  localparam int STAT_PORT_EXT  = 3;

  // Reset values and the zero transport address.
  localparam logic [CFG_W-1:0] CONFIG_RESET  = 4'h3;
  localparam logic [15:0]      HANDLER_RESET = 16'h0001;
  localparam logic [15:0]      ADDR_ZERO     = 16'h0000;

  // Port control codes.
  localparam logic [1:0] PORT_NORMAL  = 2'b00;
  localparam logic [1:0] PORT_EXTEND  = 2'b01;
  localparam logic [1:0] PORT_RETRACT = 2'b10;
  localparam logic [1:0] PORT_ILLEGAL = 2'b11;

  // Element types reported by the inventory lookup.
  typedef enum logic [1:0] {
    CMC_EL_SLOT    = 2'b00,
    CMC_EL_PORT    = 2'b01,
    CMC_EL_DRIVE   = 2'b10,
    CMC_EL_HANDLER = 2'b11
  } cmc_elem_t;

  typedef enum logic [2:0] {
    CMC_IDLE   = 3'b000,
    CMC_CHK_T  = 3'b001,
    CMC_CHK_S  = 3'b010,
    CMC_CHK_D  = 3'b011,
    CMC_PICK   = 3'b100,
    CMC_INV_H1 = 3'b101,
    CMC_PLACE  = 3'b110,
    CMC_INV_H0 = 3'b111
  } cmc_state_t;

  typedef struct packed {
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic        cd;
    logic        bpv;
    logic [2:0]  bp;
    logic [15:0] fp;
  } cmc_sense_t;

  localparam cmc_sense_t SNS_NONE       = '{4'h0, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0, 16'h0000};
  localparam cmc_sense_t SNS_NOT_READY  = '{4'h2, 8'h04, 8'h00, 1'b0, 1'b0, 3'h0, 16'h0000};
  localparam cmc_sense_t SNS_DST_FULL   = '{4'h5, 8'h3b, 8'h0d, 1'b1, 1'b0, 3'h0, 16'h0006};
  localparam cmc_sense_t SNS_SRC_EMPTY  = '{4'h5, 8'h3b, 8'h0e, 1'b1, 1'b0, 3'h0, 16'h0004};
  localparam cmc_sense_t SNS_PREVENTED  = '{4'h5, 8'h53, 8'h02, 1'b0, 1'b0, 3'h0, 16'h0000};
  localparam cmc_sense_t SNS_CFG_SRC    = '{4'h5, 8'h80, 8'h07, 1'b1, 1'b0, 3'h0, 16'h0004};
  localparam cmc_sense_t SNS_CFG_DST    = '{4'h5, 8'h80, 8'h07, 1'b1, 1'b0, 3'h0, 16'h0006};
  localparam cmc_sense_t SNS_CFG_PORT   = '{4'h5, 8'h80, 8'h07, 1'b1, 1'b1, 3'h7, 16'h000b};
  localparam cmc_sense_t SNS_ILLEGAL    = '{4'h5, 8'h24, 8'h00, 1'b1, 1'b1, 3'h7, 16'h000b};
  localparam cmc_sense_t SNS_BAD_TRANS  = '{4'h5, 8'h21, 8'h01, 1'b1, 1'b0, 3'h0, 16'h0002};
  localparam cmc_sense_t SNS_BAD_SRC    = '{4'h5, 8'h21, 8'h01, 1'b1, 1'b0, 3'h0, 16'h0004};
  localparam cmc_sense_t SNS_BAD_DST    = '{4'h5, 8'h21, 8'h01, 1'b1, 1'b0, 3'h0, 16'h0006};
  localparam cmc_sense_t SNS_NOT_EJECT  = '{4'h5, 8'h3b, 8'h90, 1'b1, 1'b0, 3'h0, 16'h0004};
  localparam cmc_sense_t SNS_HANDLER    = '{4'h5, 8'h80, 8'h01, 1'b1, 1'b0, 3'h0, 16'h0002};
  localparam cmc_sense_t SNS_NO_SRC_MAG = '{4'h5, 8'h80, 8'h03, 1'b0, 1'b0, 3'h0, 16'h0000};
  localparam cmc_sense_t SNS_NO_DST_MAG = '{4'h5, 8'h80, 8'h04, 1'b0, 1'b0, 3'h0, 16'h0000};
  localparam cmc_sense_t SNS_NO_SRC_DRV = '{4'h5, 8'h80, 8'h05, 1'b0, 1'b0, 3'h0, 16'h0000};
  localparam cmc_sense_t SNS_NO_DST_DRV = '{4'h5, 8'h80, 8'h06, 1'b0, 1'b0, 3'h0, 16'h0000};

endpackage

// File: logic/cmc_sense_latch.sv
// Holder for the sense data of the most recent failed command.
`timescale 1ns/100ps
`default_nettype none
module cmc_sense_latch (
  input  wire logic                hclk,      // System clock.
  input  wire logic                hresetn,   // Asynchronous reset, active low.
  input  wire logic                set,       // Latch new sense data.
  input  wire cmc_pkg::cmc_sense_t sense_in,  // Sense data to latch.
  output cmc_pkg::cmc_sense_t      sense_out  // Latched sense data.
);

  cmc_pkg::cmc_sense_t sense_reg;
  cmc_pkg::cmc_sense_t sense_next;

  assign sense_next = set ? sense_in : sense_reg;
  assign sense_out  = sense_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_reg <= cmc_pkg::SNS_NONE;
    end else begin
      sense_reg <= sense_next;
    end
  end

endmodule
`default_nettype wire

// File: test/cmc_move_sva.sv
// Checker on the ports of the cartridge move command block.
`timescale 1ns/100ps
`default_nettype none
module cmc_move_sva (
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, picked, placed, move_fail,
  input wire logic [1:0]  htrans,
  input wire logic        q_full, handler_full, pick_req, place_req, inv_wr, inv_full, port_extended, cart_inserted,
  input wire logic [15:0] q_addr, pick_src, place_dst, inv_addr
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pick_after_check: assert property ($rose(pick_req) && pick_src != place_dst |->
    $past(q_addr == place_dst && !q_full && !handler_full) && $past(q_addr == pick_src && q_full, 2))
    else $error("pick started without passing checks");
  a_pick_holds: assert property (pick_req && !picked && !move_fail |=> pick_req)
    else $error("pick request dropped early");
  a_place_holds: assert property (place_req && !placed && !move_fail |=> place_req)
    else $error("place request dropped early");
  a_src_emptied: assert property (picked && pick_req |-> ##[1:2] inv_wr && !inv_full && inv_addr == pick_src)
    else $error("source not marked empty");
  a_dst_filled: assert property (placed && place_req |-> ##[1:3] inv_wr && inv_full && inv_addr == place_dst)
    else $error("destination not marked full");
  a_abort_stops: assert property (move_fail |=> !pick_req && !place_req)
    else $error("motion continued after abort");
  a_insert_retracts: assert property (cart_inserted && port_extended |=> !port_extended)
    else $error("port stayed out after insertion");
  a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_resp_okay: assert property (!hresp)
    else $error("bus response was not okay");
  c_placed: cover property (placed);
  c_abort: cover property (move_fail);
  c_retract: cover property ($fell(port_extended));
endmodule
bind cmc_move cmc_move_sva u_sva (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout, .hresp, .picked, .placed,
  .move_fail, .htrans, .q_full, .handler_full, .pick_req, .place_req, .inv_wr, .inv_full, .port_extended,
  .cart_inserted, .q_addr, .pick_src, .place_dst, .inv_addr);
`default_nettype wire

// File: test/cmc_handler_model.sv
// Behavioural handler and inventory: 1 handler, 2 port, 3 and 15 drives, 14 absent magazine, others slots.
`timescale 1ns/100ps
`default_nettype none
module cmc_handler_model (
  input wire logic        hclk, pick_req, place_req, inv_wr, inv_full, abort,
  input wire logic [3:0]  slow,
  input wire logic [15:0] q_addr, inv_addr,
  output logic            q_valid, q_full, q_ejected, q_installed, handler_full,
  output logic [1:0]      q_type,
  output logic            picked = 1'b0, placed = 1'b0, move_fail = 1'b0
);
  logic [15:0] full = 16'h8018;
  logic [3:0]  wait_cnt = 4'h0;
  wire logic   go = (pick_req | place_req) && wait_cnt == slow && !picked && !placed && !move_fail;
  assign q_valid = q_addr != 16'h0000 && q_addr < 16'h0010;
  assign q_full = full[q_addr[3:0]];
  assign q_type = q_addr == 16'h0001 ? 2'd3 : q_addr == 16'h0002 ? 2'd1 :
                  (q_addr == 16'h0003 || q_addr == 16'h000f) ? 2'd2 : 2'd0;
  assign q_ejected = q_addr != 16'h000f;
  assign q_installed = q_addr != 16'h000e;
  assign handler_full = full[1];
  always @(posedge hclk) begin
    wait_cnt <= (pick_req | place_req) && !go ? wait_cnt + 4'h1 : 4'h0;
    picked <= go && pick_req && !abort;
    placed <= go && place_req && !abort;
    move_fail <= go && abort;
    if (inv_wr) full[inv_addr[3:0]] <= inv_full;
  end
endmodule
`default_nettype wire

// File: test/cartridge_move_command_test.sv
// Self-checking bench for the cartridge move command block.
`timescale 1ns/100ps
`default_nettype none
module cartridge_move_command_test;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, abort = 1'b0, cart_inserted = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [3:0]  slow = 4'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
  wire logic   hreadyout, q_valid, q_full, q_ejected, q_installed, handler_full, picked, placed, move_fail;
  wire logic   pick_req, place_req, inv_wr, inv_full, port_extended;
  wire logic [1:0]  q_type;
  wire logic [15:0] q_addr, pick_src, place_dst, inv_addr;
  wire logic [31:0] hrdata;
  int miscompares = 0, comparisons = 0;
  cmc_move dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .q_addr, .q_valid, .q_full, .q_type, .q_ejected,
    .q_installed, .handler_full, .pick_req, .pick_src, .picked, .place_req, .place_dst, .placed,
    .move_fail, .inv_wr, .inv_addr, .inv_full, .port_extended, .cart_inserted);
  cmc_handler_model partner (.hclk, .pick_req, .place_req, .inv_wr, .inv_full, .abort, .slow, .q_addr,
    .inv_addr, .q_valid, .q_full, .q_ejected, .q_installed, .handler_full, .q_type, .picked, .placed, .move_fail);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic run(input logic [15:0] t, s, d, input logic [1:0] pc, input cmc_pkg::cmc_sense_t e);
    bus(1'b1, cmc_pkg::ADDR_TRANSPORT, {16'h0, t});
    bus(1'b1, cmc_pkg::ADDR_SOURCE, {16'h0, s});
    bus(1'b1, cmc_pkg::ADDR_DEST, {16'h0, d});
    bus(1'b1, cmc_pkg::ADDR_CONTROL, {24'h0, pc, 6'h0});
    bus(1'b1, cmc_pkg::ADDR_GO, 32'h1);
    rd = 32'h0;
    for (int i = 0; i < 100 && rd[cmc_pkg::STAT_DONE] !== 1'b1; i++) bus(1'b0, cmc_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'h6, e == cmc_pkg::SNS_NONE ? 32'h2 : 32'h6);
    if (e != cmc_pkg::SNS_NONE) begin
      bus(1'b0, cmc_pkg::ADDR_SENSE0, 32'h0);
      check(rd, {1'b0, e.bp, 2'b0, e.bpv, e.cd, e.ascq, e.asc, 4'h0, e.key});
      bus(1'b0, cmc_pkg::ADDR_SENSE1, 32'h0);
      check(rd, {16'h0, e.fp});
    end
  endtask
  task automatic t_moves;
    bus(1'b0, cmc_pkg::ADDR_CONFIG, 32'h0);
    check(rd, 32'h3);
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    slow <= 4'h3;
    run(16'h0, 16'h4, 16'h5, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_NONE);
    check({30'h0, partner.full[5:4]}, 32'h2);
    run(16'h1, 16'h5, 16'h5, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_NONE);
    run(16'h1, 16'h4, 16'h4, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_SRC_EMPTY);
    run(16'h0, 16'h6, 16'h5, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_SRC_EMPTY);
    run(16'h0, 16'h3, 16'h5, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_DST_FULL);
    run(16'h7, 16'h3, 16'h6, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_BAD_TRANS);
    run(16'h0, 16'h3, 16'h20, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_BAD_DST);
    run(16'h0, 16'hf, 16'h6, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_NOT_EJECT);
    run(16'h0, 16'h3, 16'he, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_NO_DST_MAG);
    abort <= 1'b1;
    run(16'h0, 16'h3, 16'h6, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_NOT_READY);
    abort <= 1'b0;
  endtask
  task automatic t_port;
    slow <= 4'h0;
    bus(1'b1, cmc_pkg::ADDR_CONFIG, 32'h0);
    run(16'h0, 16'h3, 16'h2, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_CFG_DST);
    run(16'h0, 16'h2, 16'h5, cmc_pkg::PORT_NORMAL, cmc_pkg::SNS_CFG_SRC);
    bus(1'b1, cmc_pkg::ADDR_CONFIG, 32'h7);
    run(16'h0, 16'h0, 16'h0, cmc_pkg::PORT_EXTEND, cmc_pkg::SNS_CFG_PORT);
    bus(1'b1, cmc_pkg::ADDR_CONFIG, 32'hb);
    run(16'h0, 16'h0, 16'h0, cmc_pkg::PORT_EXTEND, cmc_pkg::SNS_PREVENTED);
    bus(1'b1, cmc_pkg::ADDR_CONFIG, 32'h3);
    run(16'h7, 16'h0, 16'h0, cmc_pkg::PORT_EXTEND, cmc_pkg::SNS_NONE);
    check({31'h0, port_extended}, 32'h1);
    @(posedge hclk) cart_inserted <= 1'b1;
    @(posedge hclk) cart_inserted <= 1'b0;
    @(posedge hclk);
    check({31'h0, port_extended}, 32'h0);
    run(16'h0, 16'h0, 16'h0, cmc_pkg::PORT_EXTEND, cmc_pkg::SNS_NONE);
    run(16'h0, 16'h0, 16'h0, cmc_pkg::PORT_RETRACT, cmc_pkg::SNS_NONE);
    check({31'h0, port_extended}, 32'h0);
    run(16'h0, 16'h0, 16'h0, cmc_pkg::PORT_ILLEGAL, cmc_pkg::SNS_ILLEGAL);
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #5 hclk = ~hclk;
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_moves;
    t_port;
    report_and_stop;
  end
endmodule
`default_nettype wire
